/* design/hsq_homing_seq.sv */
`include "hsq_defs.svh"
module hsq_homing_seq #(
   parameter int unsigned NSYNC = 2
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // object access from the motion master
   input  wire logic        obj_wr_i,
   input  wire logic        obj_rd_i,
   input  wire logic [15:0] obj_index_i,
   input  wire logic [31:0] obj_wdata_i,
   output logic      [31:0] obj_rdata_o,
   output logic             obj_ack_o,
   output logic             obj_err_o,
   // axis pins, asynchronous
   input  wire logic        origin_i,
   input  wire logic        pos_limit_i,
   input  wire logic        neg_limit_i,
   // drive state, same clock
   input  wire logic        servo_on_i,
   input  wire logic        backlash_done_i,
   input  wire logic        abs_encoder_i,
   input  wire logic        latch_active_i,
   input  wire logic        cfg_reload_i,
   input  wire logic [31:0] following_error_i,
   // motion and position outputs
   output logic             move_pos_o,
   output logic             move_neg_o,
   output logic             limit_stop_en_o,
   output logic             preset_load_o,
   output logic      [31:0] demand_pos_o,
   output logic      [31:0] filt_demand_pos_o,
   output logic      [31:0] actual_pos_o,
   output logic             latch_cancel_o,
   // status
   output logic      [15:0] statusword_o,
   output logic             homing_attained_o,
   output logic             homing_fault_o,
   output logic             prohib_err_o
);
   // elaboration check: a synchroniser needs two stages
   if (NSYNC != 2) begin : g_bad_nsync
      $error("hsq_homing_seq: NSYNC must be 2");
   end

   hsq_obj_if obj ();

   hsq_obj_store u_store (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .wr_i    (obj_wr_i),
      .rd_i    (obj_rd_i),
      .index_i (obj_index_i),
      .wdata_i (obj_wdata_i),
      .rdata_o (obj_rdata_o),
      .ack_o   (obj_ack_o),
      .err_o   (obj_err_o),
      .obj     (obj)
   );

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic [2:0] pin_raw;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   assign pin_raw = {origin_i, pos_limit_i, neg_limit_i};

   // two flops per pin; only stage two is read
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
         end else begin
            sync1_q[i] <= pin_raw[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   logic origin_s, plim_s, nlim_s;
   assign origin_s = sync2_q[2];
   assign plim_s   = sync2_q[1];
   assign nlim_s   = sync2_q[0];

   // ***************************************************
   // sequencer
   // ***************************************************
   hsq_pkg::hsq_state_t state_q, state_d;
   logic        dir_pos_q, dir_pos_d;
   logic        att_q, att_d;
   logic        fault_q, fault_d;
   logic        perr_q, perr_d;
   logic        preset_q, preset_d;
   logic        lcancel_q, lcancel_d;
   logic        start_prev_q;
   logic        orig_prev_q;
   logic [31:0] dem_q, dem_d;
   logic [31:0] filt_q, filt_d;
   logic [31:0] act_q, act_d;
   logic [15:0] status_q, status_d;
   logic        mpos_q, mpos_d;
   logic        mneg_q, mneg_d;
   logic        lstop_q, lstop_d;
   logic        start_bit, start_rise, in_hm, orig_rise, both_lim, dir_lim, any_lim;
   logic [1:0]  sel;

   assign start_bit  = obj.ctrl[`HSQ_BIT_CTRL_START];
   assign start_rise = start_bit & ~start_prev_q;
   assign in_hm      = (obj.op_mode == `HSQ_OPMODE_HM);
   assign orig_rise  = origin_s & ~orig_prev_q;
   assign both_lim   = plim_s & nlim_s;
   assign any_lim    = plim_s | nlim_s;
   assign dir_lim    = dir_pos_q ? plim_s : nlim_s;
   assign sel        = obj.prohib_sel;

   // next-state logic for the whole sequence
   always_comb begin
      state_d   = state_q;
      dir_pos_d = dir_pos_q;
      att_d     = att_q;
      fault_d   = fault_q;
      perr_d    = perr_q;
      preset_d  = 1'b0;
      lcancel_d = 1'b0;
      dem_d     = dem_q;
      filt_d    = filt_q;
      act_d     = act_q;
      case (state_q)
         hsq_pkg::HSQ_IDLE, hsq_pkg::HSQ_DONE, hsq_pkg::HSQ_FAIL: begin
            if (start_rise && in_hm) begin
               fault_d = 1'b0;
               perr_d  = 1'b0;
               case (obj.method)
                  `HSQ_METHOD_NEG: begin
                     dir_pos_d = 1'b0;
                     att_d     = 1'b0;
                     state_d   = hsq_pkg::HSQ_MOVE;
                  end
                  `HSQ_METHOD_POS: begin
                     dir_pos_d = 1'b1;
                     att_d     = 1'b0;
                     state_d   = hsq_pkg::HSQ_MOVE;
                  end
                  `HSQ_METHOD_PRESET: begin
                     if (!servo_on_i) begin
                        // an ignored request must not wipe an earlier fault
                        state_d = state_q;
                        fault_d = fault_q;
                        perr_d  = perr_q;
                     end else if (!backlash_done_i || obj.op_mode == `HSQ_OPMODE_CSV
                                  || obj.op_mode == `HSQ_OPMODE_CST) begin
                        fault_d = 1'b1;
                        state_d = hsq_pkg::HSQ_FAIL;
                     end else if (!obj.set_mode[`HSQ_BIT_LOAD_POS]) begin
                        fault_d = 1'b1;
                        state_d = hsq_pkg::HSQ_FAIL;
                     end else begin
                        dem_d     = obj.set_pos;
                        filt_d    = obj.set_pos;
                        act_d     = obj.set_pos - following_error_i;
                        preset_d  = 1'b1;
                        lcancel_d = latch_active_i;
                        att_d     = abs_encoder_i | obj.set_mode[`HSQ_BIT_ATT_SEL];
                        state_d   = hsq_pkg::HSQ_DONE;
                     end
                  end
                  default: begin
                     fault_d = 1'b1;
                     state_d = hsq_pkg::HSQ_FAIL;
                  end
               endcase
            end
         end
         hsq_pkg::HSQ_MOVE: begin
            if (!start_bit || !in_hm) begin
               state_d = hsq_pkg::HSQ_IDLE;
            end else if (both_lim && sel == `HSQ_SEL_BOTH_ERR) begin
               perr_d  = 1'b1;
               state_d = hsq_pkg::HSQ_FAIL;
            end else if (any_lim && sel == `HSQ_SEL_ONE_ERR) begin
               perr_d  = 1'b1;
               state_d = hsq_pkg::HSQ_FAIL;
            end else if (both_lim) begin
               fault_d = 1'b1;
               state_d = hsq_pkg::HSQ_FAIL;
            end else if (orig_rise) begin
               att_d   = 1'b1;
               state_d = hsq_pkg::HSQ_DONE;
            end else if (dir_lim) begin
               fault_d = 1'b1;
               state_d = hsq_pkg::HSQ_FAIL;
            end
         end
         default: begin
            state_d = hsq_pkg::HSQ_IDLE;
         end
      endcase
      // reload discards the preset origin; no home offset is written
      // a preset or origin completion in the same cycle wins over the reload
      if (cfg_reload_i && !preset_d
          && !(state_q == hsq_pkg::HSQ_MOVE && state_d == hsq_pkg::HSQ_DONE)) begin
         att_d = 1'b0;
      end
   end

   // output decode, computed from next values so outputs are flops
   always_comb begin
      mpos_d   = (state_d == hsq_pkg::HSQ_MOVE) & dir_pos_d;
      mneg_d   = (state_d == hsq_pkg::HSQ_MOVE) & ~dir_pos_d;
      lstop_d  = (state_d != hsq_pkg::HSQ_MOVE);
      status_d = 16'h0000;
      case (state_d)
         hsq_pkg::HSQ_MOVE: status_d = 16'h0000;
         hsq_pkg::HSQ_DONE: begin
            status_d[`HSQ_BIT_ST_ATT]    = att_d;
            status_d[`HSQ_BIT_ST_TARGET] = 1'b1;
         end
         hsq_pkg::HSQ_FAIL: begin
            status_d[`HSQ_BIT_ST_ERR]    = 1'b1;
            status_d[`HSQ_BIT_ST_TARGET] = 1'b1;
         end
         default: status_d[`HSQ_BIT_ST_TARGET] = 1'b1;
      endcase
   end

   // register every sequencer value; reset also drops any preset origin
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q      <= hsq_pkg::HSQ_IDLE;
         dir_pos_q    <= 1'b0;
         att_q        <= 1'b0;
         fault_q      <= 1'b0;
         perr_q       <= 1'b0;
         preset_q     <= 1'b0;
         lcancel_q    <= 1'b0;
         start_prev_q <= 1'b0;
         orig_prev_q  <= 1'b0;
         dem_q        <= 32'h0000_0000;
         filt_q       <= 32'h0000_0000;
         act_q        <= 32'h0000_0000;
         status_q     <= 16'h0400;
         mpos_q       <= 1'b0;
         mneg_q       <= 1'b0;
         lstop_q      <= 1'b1;
      end else begin
         state_q      <= state_d;
         dir_pos_q    <= dir_pos_d;
         att_q        <= att_d;
         fault_q      <= fault_d;
         perr_q       <= perr_d;
         preset_q     <= preset_d;
         lcancel_q    <= lcancel_d;
         start_prev_q <= start_bit;
         orig_prev_q  <= origin_s;
         dem_q        <= dem_d;
         filt_q       <= filt_d;
         act_q        <= act_d;
         status_q     <= status_d;
         mpos_q       <= mpos_d;
         mneg_q       <= mneg_d;
         lstop_q      <= lstop_d;
      end
   end

   assign obj.status        = status_q;
   assign statusword_o      = status_q;
   assign move_pos_o        = mpos_q;
   assign move_neg_o        = mneg_q;
   assign limit_stop_en_o   = lstop_q;
   assign preset_load_o     = preset_q;
   assign demand_pos_o      = dem_q;
   assign filt_demand_pos_o = filt_q;
   assign actual_pos_o      = act_q;
   assign latch_cancel_o    = lcancel_q;
   assign homing_attained_o = att_q;
   assign homing_fault_o    = fault_q;
   assign prohib_err_o      = perr_q;
endmodule : hsq_homing_seq

/* design/hsq_defs.svh */
`ifndef HSQ_DEFS_SVH
`define HSQ_DEFS_SVH
// Overview of operation
// - origin-only homing: method 33 starts negative, method 34 starts positive
// - both travel limits active together during origin homing raises homing fault unless limit selection is 0 or 2
// - limit in travel direction before any origin pulse raises homing fault unless limit selection is 2
// - stop-on-limit behaviour is suppressed only while origin homing (method 33 or 34) runs; a method 35 preset leaves it enabled
// - limit selection 0: both-side limits give limit error 38.0
// - limit selection 1: both-side limits give homing fault, not limit error
// - limit selection 2: single-side limit gives 38.0; master should avoid 2
// - method 35 takes present position as origin with no motion
// - preset origin never stored in home offset; lost on power loss or reload
// - preset runs only in homing mode with servo energized
// - preset during an active position latch cancels the latch
// - preset before backlash done is a fault; in cyclic velocity/torque mode the request is ignored
// - setting mode word: bit7 attained select, bits 3..0 load select, default 83h
// - load select bit3 set: setting position copied to demand and filtered demand
// - actual position loaded with filtered demand minus following error
// - load select bit3 clear at preset raises homing fault
// - attained select 0 leaves homing not attained, 1 reports attained
// - attained select only matters for incremental encoder; absolute always attained
// - setting position is signed 32-bit command units, default zero
// - status bits 13,12,10 encode homing state

// ***************************************************
// object indices
// ***************************************************
`define HSQ_IDX_CTRL       16'h6040
`define HSQ_IDX_STATUS     16'h6041
`define HSQ_IDX_OPMODE     16'h6060
`define HSQ_IDX_METHOD     16'h6098
`define HSQ_IDX_SET_MODE   16'h4103
`define HSQ_IDX_SET_POS    16'h4104
`define HSQ_IDX_PROHIB_SEL 16'h3504

// ***************************************************
// reset values and field positions
// ***************************************************
`define HSQ_SET_MODE_RST   16'h0083
`define HSQ_SET_MODE_MASK  16'h008f
`define HSQ_SET_POS_RST    32'h0000_0000
`define HSQ_CTRL_RST       16'h0000
`define HSQ_OPMODE_RST     8'h00
`define HSQ_METHOD_RST     8'h00
`define HSQ_PROHIB_SEL_RST 2'h1
`define HSQ_BIT_ATT_SEL    7
`define HSQ_BIT_LOAD_POS   3
`define HSQ_BIT_CTRL_START 4
`define HSQ_BIT_ST_TARGET  10
`define HSQ_BIT_ST_ATT     12
`define HSQ_BIT_ST_ERR     13

// ***************************************************
// modes and methods
// ***************************************************
`define HSQ_OPMODE_HM      8'h06
`define HSQ_OPMODE_CSV     8'h09
`define HSQ_OPMODE_CST     8'h0a
`define HSQ_METHOD_NEG     8'h21
`define HSQ_METHOD_POS     8'h22
`define HSQ_METHOD_PRESET  8'h23
`define HSQ_SEL_BOTH_ERR   2'h0
`define HSQ_SEL_BOTH_FAULT 2'h1
`define HSQ_SEL_ONE_ERR    2'h2
`endif

/* design/hsq_pkg.sv */
package hsq_pkg;
   // sequencer states, gray along idle -> move -> done
   typedef enum logic [1:0] {
      HSQ_IDLE = 2'h0,
      HSQ_MOVE = 2'h1,
      HSQ_DONE = 2'h3,
      HSQ_FAIL = 2'h2
   } hsq_state_t;
endpackage : hsq_pkg

/* design/hsq_obj_if.sv */
interface hsq_obj_if;
   logic [15:0] set_mode;
   logic [31:0] set_pos;
   logic [15:0] ctrl;
   logic [7:0]  op_mode;
   logic [7:0]  method;
   logic [1:0]  prohib_sel;
   logic [15:0] status;
   modport store (output set_mode, set_pos, ctrl, op_mode, method, prohib_sel, input status);
   modport seq   (input set_mode, set_pos, ctrl, op_mode, method, prohib_sel, output status);
endinterface : hsq_obj_if

/* design/hsq_obj_store.sv */
`include "hsq_defs.svh"
module hsq_obj_store (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // object access
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [15:0] index_i,
   input  wire logic [31:0] wdata_i,
   output logic      [31:0] rdata_o,
   output logic             ack_o,
   output logic             err_o,
   // to the sequencer
   hsq_obj_if.store         obj
);
   logic [15:0] set_mode_q, set_mode_d;
   logic [31:0] set_pos_q,  set_pos_d;
   logic [15:0] ctrl_q,     ctrl_d;
   logic [7:0]  opmode_q,   opmode_d;
   logic [7:0]  method_q,   method_d;
   logic [1:0]  sel_q,      sel_d;
   logic [31:0] rdata_q,    rdata_d;
   logic        ack_q,      ack_d;
   logic        err_q,      err_d;
   logic        hit;

   // ***************************************************
   // write and read decode
   // ***************************************************
   always_comb begin
      set_mode_d = set_mode_q;
      set_pos_d  = set_pos_q;
      ctrl_d     = ctrl_q;
      opmode_d   = opmode_q;
      method_d   = method_q;
      sel_d      = sel_q;
      rdata_d    = 32'h0000_0000;
      hit        = 1'b1;
      case (index_i)
         `HSQ_IDX_SET_MODE:   rdata_d = {16'h0000, set_mode_q};
         `HSQ_IDX_SET_POS:    rdata_d = set_pos_q;
         `HSQ_IDX_CTRL:       rdata_d = {16'h0000, ctrl_q};
         `HSQ_IDX_STATUS:     rdata_d = {16'h0000, obj.status};
         `HSQ_IDX_OPMODE:     rdata_d = {24'h00_0000, opmode_q};
         `HSQ_IDX_METHOD:     rdata_d = {24'h00_0000, method_q};
         `HSQ_IDX_PROHIB_SEL: rdata_d = {30'h0, sel_q};
         default:             hit = 1'b0;
      endcase
      if (wr_i) begin
         case (index_i)
            `HSQ_IDX_SET_MODE:   set_mode_d = wdata_i[15:0] & `HSQ_SET_MODE_MASK;
            `HSQ_IDX_SET_POS:    set_pos_d = wdata_i;
            `HSQ_IDX_CTRL:       ctrl_d = wdata_i[15:0];
            `HSQ_IDX_OPMODE:     opmode_d = wdata_i[7:0];
            `HSQ_IDX_METHOD:     method_d = wdata_i[7:0];
            `HSQ_IDX_PROHIB_SEL: sel_d = wdata_i[1:0];
            default:             sel_d = sel_q;
         endcase
      end
      ack_d = wr_i | rd_i;
      err_d = (wr_i | rd_i) & (~hit | (wr_i & (index_i == `HSQ_IDX_STATUS)));
      if (!rd_i) begin
         rdata_d = rdata_q;
      end
   end

   // object registers, defaults from reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         set_mode_q <= `HSQ_SET_MODE_RST;
         set_pos_q  <= `HSQ_SET_POS_RST;
         ctrl_q     <= `HSQ_CTRL_RST;
         opmode_q   <= `HSQ_OPMODE_RST;
         method_q   <= `HSQ_METHOD_RST;
         sel_q      <= `HSQ_PROHIB_SEL_RST;
         rdata_q    <= 32'h0000_0000;
         ack_q      <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         set_mode_q <= set_mode_d;
         set_pos_q  <= set_pos_d;
         ctrl_q     <= ctrl_d;
         opmode_q   <= opmode_d;
         method_q   <= method_d;
         sel_q      <= sel_d;
         rdata_q    <= rdata_d;
         ack_q      <= ack_d;
         err_q      <= err_d;
      end
   end

   assign obj.set_mode   = set_mode_q;
   assign obj.set_pos    = set_pos_q;
   assign obj.ctrl       = ctrl_q;
   assign obj.op_mode    = opmode_q;
   assign obj.method     = method_q;
   assign obj.prohib_sel = sel_q;
   assign rdata_o        = rdata_q;
   assign ack_o          = ack_q;
   assign err_o          = err_q;
endmodule : hsq_obj_store

/* tb/hsq_homing_seq_props.sv */
module hsq_homing_seq_props (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rstn_i,
   // drive inputs
   input wire logic        cfg_reload_i,
   input wire logic        abs_encoder_i,
   input wire logic [31:0] following_error_i,
   // observed outputs
   input wire logic        move_pos_o,
   input wire logic        move_neg_o,
   input wire logic        limit_stop_en_o,
   input wire logic        preset_load_o,
   input wire logic [31:0] demand_pos_o,
   input wire logic [31:0] filt_demand_pos_o,
   input wire logic [31:0] actual_pos_o,
   input wire logic        latch_cancel_o,
   input wire logic [15:0] statusword_o,
   input wire logic        homing_attained_o,
   input wire logic        homing_fault_o,
   input wire logic        prohib_err_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***************************************************
   // homing output relations
   // ***************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // driving both ways at once would fight the axis
   chk_one_direction: assert property (!(move_pos_o && move_neg_o))
      else $error("both motion directions commanded");
   chk_stop_suppressed: assert property ((move_pos_o || move_neg_o) |-> !limit_stop_en_o)
      else $error("stop on limit enabled while moving");
   chk_move_status: assert property ((move_pos_o || move_neg_o) |-> statusword_o[13:10] == 4'h0)
      else $error("status not in progress while moving");
   chk_error_status: assert property ((homing_fault_o || prohib_err_o) |-> statusword_o[13:12] == 2'h2)
      else $error("error status bits wrong");
   chk_load_copy: assert property (preset_load_o |-> demand_pos_o == filt_demand_pos_o)
      else $error("demand and filtered demand differ at preset");
   // following error sampled on the load edge
   chk_actual_pos: assert property (preset_load_o |-> actual_pos_o == filt_demand_pos_o - $past(following_error_i))
      else $error("actual position not demand minus error");
   chk_load_pulse: assert property (preset_load_o |=> !preset_load_o)
      else $error("preset load longer than one cycle");
   chk_latch_cancel: assert property (latch_cancel_o |-> preset_load_o)
      else $error("latch cancel without preset");
   // a completion landing with the reload keeps attained set
   chk_reload_clear: assert property (cfg_reload_i |=> !homing_attained_o || preset_load_o
      || $fell(move_pos_o || move_neg_o))
      else $error("attained survives reload");
   chk_abs_attained: assert property (preset_load_o && $past(abs_encoder_i) |-> homing_attained_o)
      else $error("absolute encoder preset not attained");
   chk_fault_no_load: assert property (homing_fault_o |-> !preset_load_o)
      else $error("positions loaded with fault");
   cov_preset: cover property (preset_load_o);
   cov_move_neg: cover property (move_neg_o);
   cov_prohib: cover property (prohib_err_o);
   cov_fault: cover property ($rose(homing_fault_o));
endmodule : hsq_homing_seq_props

bind hsq_homing_seq hsq_homing_seq_props u_props (.clk_i, .rstn_i, .cfg_reload_i, .abs_encoder_i,
   .following_error_i, .move_pos_o, .move_neg_o, .limit_stop_en_o, .preset_load_o, .demand_pos_o,
   .filt_demand_pos_o, .actual_pos_o, .latch_cancel_o, .statusword_o, .homing_attained_o,
   .homing_fault_o, .prohib_err_o);

/* tb/hsq_master_model.sv */
module hsq_master_model (
   // clock
   input  wire logic        clk_i,
   // object access
   output logic             obj_wr_o,
   output logic             obj_rd_o,
   output logic      [15:0] obj_index_o,
   output logic      [31:0] obj_wdata_o,
   input  wire logic [31:0] obj_rdata_i,
   input  wire logic        obj_ack_i,
   input  wire logic        obj_err_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      obj_wr_o = 1'b0;
      obj_rd_o = 1'b0;
      obj_index_o = 16'h0000;
      obj_wdata_o = 32'h0000_0000;
   end
   // one whole object per access; answer taken the cycle after the strobe
   task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
                         output logic [31:0] q, output logic [1:0] ae);
      @(negedge clk_i);
      obj_wr_o = w;
      obj_rd_o = !w;
      obj_index_o = i;
      obj_wdata_o = d;
      @(negedge clk_i);
      obj_wr_o = 1'b0;
      obj_rd_o = 1'b0;
      // released lines flip so a stale value is never mistaken for valid
      obj_index_o = ~i;
      obj_wdata_o = ~d;
      q = obj_rdata_i;
      ae = {obj_ack_i, obj_err_i};
   endtask : access
endmodule : hsq_master_model

/* tb/tb_top.sv */
`include "hsq_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [15:0] mode;
      logic        abs_enc;
      logic        att;
      logic        flt;
      logic [15:0] stat;
      logic [31:0] pos;
   } hsq_row_t;
   typedef struct packed {
      logic [1:0] sel;
      logic       pl;
      logic       nl;
      logic       flt;
      logic       perr;
   } hsq_lim_t;
   logic        clk_i, rstn_i, wr, rd, origin, pos_lim, neg_lim, servo_on, bl_done;
   logic        abs_enc, latch_act, reload, ack, err, mv_p, mv_n, lse, pload, lcan, att, flt, perr;
   logic [15:0] idx, status;
   logic [31:0] wdata, rdata, ferr, dpos, fpos, apos, last_q;
   int          n_mismatch = 0;
   int          comparisons = 0;
   // preset cases: mode, encoder, attained, fault, status, position
   hsq_row_t rows [4] = '{
      '{16'h0088, 1'b0, 1'b1, 1'b0, 16'h1400, 32'h8000_0000},
      '{16'h0008, 1'b0, 1'b0, 1'b0, 16'h0400, 32'h7fff_ffff},
      '{16'h0008, 1'b1, 1'b1, 1'b0, 16'h1400, 32'h0000_0005},
      '{16'h0083, 1'b0, 1'b0, 1'b1, 16'h2400, 32'h0000_0009}};
   // limit cases while moving negative; selection 2 used on purpose
   hsq_lim_t lims [4] = '{
      '{2'h1, 1'b1, 1'b1, 1'b1, 1'b0},
      '{2'h0, 1'b1, 1'b1, 1'b0, 1'b1},
      '{2'h2, 1'b1, 1'b0, 1'b0, 1'b1},
      '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0}};

   hsq_master_model u_master (.clk_i(clk_i), .obj_wr_o(wr), .obj_rd_o(rd), .obj_index_o(idx),
      .obj_wdata_o(wdata), .obj_rdata_i(rdata), .obj_ack_i(ack), .obj_err_i(err));
   hsq_homing_seq #(.NSYNC(2)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .obj_wr_i(wr), .obj_rd_i(rd),
      .obj_index_i(idx), .obj_wdata_i(wdata), .obj_rdata_o(rdata), .obj_ack_o(ack),
      .obj_err_o(err), .origin_i(origin), .pos_limit_i(pos_lim), .neg_limit_i(neg_lim),
      .servo_on_i(servo_on), .backlash_done_i(bl_done), .abs_encoder_i(abs_enc),
      .latch_active_i(latch_act), .cfg_reload_i(reload), .following_error_i(ferr),
      .move_pos_o(mv_p), .move_neg_o(mv_n), .limit_stop_en_o(lse), .preset_load_o(pload),
      .demand_pos_o(dpos), .filt_demand_pos_o(fpos), .actual_pos_o(apos),
      .latch_cancel_o(lcan), .statusword_o(status), .homing_attained_o(att),
      .homing_fault_o(flt), .prohib_err_o(perr));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                      input logic [1:0] ae_exp);
      logic [1:0] ae;
      u_master.access(w, i, d, last_q, ae);
      check(32'(ae), 32'(ae_exp));
   endtask : acc

   // control bit 4 low then high: an edge starts homing
   task automatic start(input logic [7:0] m);
      acc(1'b1, `HSQ_IDX_METHOD, 32'(m), 2'h2);
      acc(1'b1, `HSQ_IDX_CTRL, 32'h0, 2'h2);
      acc(1'b1, `HSQ_IDX_CTRL, 32'h10, 2'h2);
      @(negedge clk_i);
   endtask : start

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      summarize();
   end
   initial begin
      {rstn_i, origin, pos_lim, neg_lim, servo_on, bl_done, abs_enc, latch_act, reload} = '0;
      ferr = 32'h0000_0010;
      repeat (16) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'b1;
      check(32'({status, lse}), 32'h0801);
      acc(1'b0, `HSQ_IDX_SET_MODE, 32'h0, 2'h2);
      check(last_q, 32'h83);
      acc(1'b0, `HSQ_IDX_SET_POS, 32'h0, 2'h2);
      check(last_q, 32'h0);
      acc(1'b1, `HSQ_IDX_SET_MODE, 32'hffff, 2'h2);
      acc(1'b0, `HSQ_IDX_SET_MODE, 32'h0, 2'h2);
      check(last_q, 32'h8f);
      acc(1'b1, `HSQ_IDX_STATUS, 32'h0, 2'h3);
      acc(1'b0, 16'h1234, 32'h0, 2'h3);
      acc(1'b1, `HSQ_IDX_OPMODE, 32'h6, 2'h2);
      servo_on = 1'b1;
      bl_done = 1'b1;
      foreach (rows[k]) begin
         abs_enc = rows[k].abs_enc;
         acc(1'b1, `HSQ_IDX_SET_MODE, 32'(rows[k].mode), 2'h2);
         acc(1'b1, `HSQ_IDX_SET_POS, rows[k].pos, 2'h2);
         start(`HSQ_METHOD_PRESET);
         check(32'({pload, mv_p, mv_n}), 32'({!rows[k].flt, 2'h0}));
         check(32'(flt), 32'(rows[k].flt));
         check(32'(status), 32'(rows[k].stat));
         if (!rows[k].flt) begin
            check(32'(att), 32'(rows[k].att));
            check(dpos, rows[k].pos);
            check(fpos, rows[k].pos);
            check(apos, rows[k].pos - ferr);
         end
      end
      foreach (lims[k]) begin
         acc(1'b1, `HSQ_IDX_PROHIB_SEL, 32'(lims[k].sel), 2'h2);
         start(`HSQ_METHOD_NEG);
         check(32'({mv_p, mv_n, lse}), 32'h2);
         check(32'(status), 32'h0);
         pos_lim = lims[k].pl;
         neg_lim = lims[k].nl;
         repeat (6) @(negedge clk_i);
         check(32'({flt, perr, mv_n}), 32'({lims[k].flt, lims[k].perr, 1'b0}));
         check(32'(status), 32'h2400);
         pos_lim = 1'b0;
         neg_lim = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      acc(1'b1, `HSQ_IDX_PROHIB_SEL, 32'h1, 2'h2);
      start(`HSQ_METHOD_POS);
      check(32'({mv_p, mv_n, lse}), 32'h4);
      origin = 1'b1;
      for (int n = 0; n < 8 && mv_p; n++) @(negedge clk_i);
      check(32'({mv_p, att, status}), 32'h1_1400);
      origin = 1'b0;
      servo_on = 1'b0;
      start(`HSQ_METHOD_PRESET);
      check(32'({pload, status}), 32'h1400);
      servo_on = 1'b1;
      acc(1'b1, `HSQ_IDX_SET_MODE, 32'h88, 2'h2);
      latch_act = 1'b1;
      start(`HSQ_METHOD_PRESET);
      check(32'({pload, lcan}), 32'h3);
      latch_act = 1'b0;
      reload = 1'b1;
      @(negedge clk_i);
      reload = 1'b0;
      @(negedge clk_i);
      check(32'(att), 32'h0);
      bl_done = 1'b0;
      start(`HSQ_METHOD_PRESET);
      check(32'({flt, pload}), 32'h2);
      // power loss in mid-run drops the preset origin and the objects
      bl_done = 1'b1;
      start(`HSQ_METHOD_PRESET);
      check(32'(att), 32'h1);
      rstn_i = 1'b0;
      @(negedge clk_i);
      rstn_i = 1'b1;
      check(32'({att, status}), 32'h0400);
      acc(1'b0, `HSQ_IDX_SET_MODE, 32'h0, 2'h2);
      check(last_q, 32'h83);
      summarize();
   end
endmodule : tb_top
